// [design/rps_consts.svh]
`ifndef RPS_CONSTS_SVH
`define RPS_CONSTS_SVH
// ****************************************
// Timing figures, as printed
// ****************************************
`define RPS_CLK_HZ        25000000
`define RPS_DEBOUNCE_MS   32
`define RPS_RESET_MS      20
`define RPS_REG_STD_US    125
`define RPS_REG_LONG_MS   10
`define RPS_HOLD_MS       500
// ****************************************
// Derived cycle counts
// ****************************************
`define RPS_MS_CYC(ms)    ((ms) * (`RPS_CLK_HZ / 1000))
`define RPS_US_CYC(us)    ((us) * (`RPS_CLK_HZ / 1000000))
// ****************************************
// Power-good hysteresis, per mille of target
// ****************************************
`define RPS_PG_RISE_PM    10'h3B6
`define RPS_PG_FALL_PM    10'h384
`define RPS_CNT_W         32
`endif

// [design/rps_pkg.sv]
package rps_pkg;
  typedef enum logic [7:0] {
    RPS_OFF      = 8'h01,
    RPS_PRI_UP   = 8'h02,
    RPS_SEC_WAIT = 8'h04,
    RPS_SEC_UP   = 8'h08,
    RPS_RST_WAIT = 8'h10,
    RPS_RUN      = 8'h20,
    RPS_SEC_DOWN = 8'h40,
    RPS_PRI_DOWN = 8'h80
  } rps_state_t;
endpackage

// [design/rps_pg_if.sv]
`timescale 1ns/100ps
interface rps_pg_if;
  logic [9:0] level;
  logic       good;
  modport mon (input level, output good);
  modport seq (output level, input good);
endinterface

// [design/rps_power_good.sv]
`timescale 1ns/100ps
`include "rps_consts.svh"
module rps_power_good (
  input wire logic clk,
  input wire logic srst,
  rps_pg_if.mon    pg
);
  // ****************************************
  // Hysteresis comparator
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      pg.good <= 1'b0;
    end else if (pg.level >= `RPS_PG_RISE_PM) begin
      pg.good <= 1'b1; // [RULE1]
    end else if (pg.level <= `RPS_PG_FALL_PM) begin
      pg.good <= 1'b0; // [RULE2]
    end
  end
endmodule

// [design/rps_sequencer.sv]
`timescale 1ns/100ps
`include "rps_consts.svh"
// Notes on behaviour
// [RULE1] Power-good sets at upper threshold
// [RULE2] Power-good clears only at lower threshold
// [RULE3] Power-good flags stay internal
// [RULE4] Reset rises reset delay after secondary good
// [RULE5] Secondary off reset delay after reset falls
// [RULE6] Secondary on regulator delay after primary good
// [RULE7] Primary off regulator delay after secondary drops
// [RULE8] Build option selects long regulator delay
// [RULE9] Hold window timed from reset rising
// [RULE10] Debounced key asserts interrupt, starts power-up
// [RULE11] Debounced external power starts power-up
// [RULE12] Hold timeout drops interrupt, reset, powers down
// [RULE13] External power keeps rails; loss starts shutdown
// [RULE14] Reset low until power-up completes
module rps_sequencer
  import rps_pkg::*;
#(
  parameter bit          LONG_REG_DELAY = 1'b0,
  parameter int unsigned DEBOUNCE_CYC   = `RPS_MS_CYC(`RPS_DEBOUNCE_MS),
  parameter int unsigned RESET_CYC      = `RPS_MS_CYC(`RPS_RESET_MS),
  parameter int unsigned REG_STD_CYC    = `RPS_US_CYC(`RPS_REG_STD_US),
  parameter int unsigned REG_LONG_CYC   = `RPS_MS_CYC(`RPS_REG_LONG_MS),
  parameter int unsigned HOLD_CYC       = `RPS_MS_CYC(`RPS_HOLD_MS)
) (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       powerKeyIn,
  input  wire logic       externalPowerDetect_n,
  input  wire logic       hostPowerKeep,
  input  wire logic [9:0] primaryLevel,
  input  wire logic [9:0] secondaryLevel,
  output logic            primaryRegulatorEn,
  output logic            secondaryRegulatorEn,
  output logic            resetOut_n,
  output logic            resetOutOe,
  output logic            irqOut_n,
  output logic            irqOutOe
);
  localparam int unsigned REG_CYC = LONG_REG_DELAY ? REG_LONG_CYC : REG_STD_CYC; // [RULE8]

  rps_state_t            state;
  logic [`RPS_CNT_W-1:0] timer;
  logic [`RPS_CNT_W-1:0] keyCnt;
  logic [`RPS_CNT_W-1:0] extCnt;
  logic                  keyValid;
  logic                  extValid;
  logic                  keyPrev;
  logic                  irqActive;
  logic                  held;
  logic                  priGood;
  logic                  secGood;
  logic                  priGoodPrev;
  logic                  secGoodPrev;

  function automatic logic reached(input logic [`RPS_CNT_W-1:0] cnt, input int unsigned lim);
    reached = (cnt >= lim[`RPS_CNT_W-1:0] - `RPS_CNT_W'h1);
  endfunction

  // ****************************************
  // Power-good monitors, never leave the block
  // ****************************************
  rps_pg_if priIf ();
  rps_pg_if secIf ();
  assign priIf.level = primaryLevel;
  assign secIf.level = secondaryLevel;
  assign priGood     = priIf.good; // [RULE3]
  assign secGood     = secIf.good; // [RULE3]

  rps_power_good uPriGood (
    .clk  (clk),
    .srst (srst),
    .pg   (priIf)
  );
  rps_power_good uSecGood (
    .clk  (clk),
    .srst (srst),
    .pg   (secIf)
  );

  // ****************************************
  // Debouncers
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst || !powerKeyIn) begin
      keyCnt   <= '0;
      keyValid <= 1'b0;
    end else if (keyCnt > DEBOUNCE_CYC[`RPS_CNT_W-1:0]) begin
      keyValid <= 1'b1; // [RULE10]
    end else begin
      keyCnt <= keyCnt + `RPS_CNT_W'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || externalPowerDetect_n) begin
      extCnt   <= '0;
      extValid <= 1'b0;
    end else if (extCnt >= DEBOUNCE_CYC[`RPS_CNT_W-1:0]) begin
      extValid <= 1'b1; // [RULE11]
    end else begin
      extCnt <= extCnt + `RPS_CNT_W'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      keyPrev     <= 1'b0;
      priGoodPrev <= 1'b0;
      secGoodPrev <= 1'b0;
    end else begin
      keyPrev     <= keyValid;
      priGoodPrev <= priGood;
      secGoodPrev <= secGood;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= RPS_OFF;
      timer <= '0;
      held  <= 1'b0;
    end else begin
      timer <= timer + `RPS_CNT_W'h1;
      case (state)
        RPS_OFF: begin
          timer <= '0;
          held  <= 1'b0;
          if ((keyValid && !keyPrev) || extValid) begin
            state <= RPS_PRI_UP; // [RULE10] [RULE11]
          end
        end
        RPS_PRI_UP: begin
          timer <= '0;
          if (priGood && !priGoodPrev) begin
            state <= RPS_SEC_WAIT;
          end
        end
        RPS_SEC_WAIT: begin
          if (reached(timer, REG_CYC)) begin
            state <= RPS_SEC_UP; // [RULE6]
          end
        end
        RPS_SEC_UP: begin
          timer <= '0;
          if (secGood && !secGoodPrev) begin
            state <= RPS_RST_WAIT;
          end
        end
        RPS_RST_WAIT: begin
          if (reached(timer, RESET_CYC)) begin
            timer <= '0;
            state <= RPS_RUN; // [RULE4]
          end
        end
        RPS_RUN: begin
          if (hostPowerKeep) begin
            held <= 1'b1;
          end
          if (timer == HOLD_CYC[`RPS_CNT_W-1:0]) begin
            timer <= timer; // [RULE9]
          end
          if (!hostPowerKeep && !extValid &&
              (held || timer >= HOLD_CYC[`RPS_CNT_W-1:0])) begin
            timer <= '0;
            state <= RPS_SEC_DOWN; // [RULE12] [RULE13]
          end
        end
        RPS_SEC_DOWN: begin
          if (reached(timer, RESET_CYC)) begin
            state <= RPS_PRI_DOWN; // [RULE5]
          end
        end
        RPS_PRI_DOWN: begin
          if (secGood) begin
            timer <= '0;
          end else if (reached(timer, REG_CYC)) begin
            state <= RPS_OFF; // [RULE7]
          end
        end
        default: begin
          state <= RPS_OFF;
        end
      endcase
    end
  end

  // ****************************************
  // Interrupt from key press to hold decision
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      irqActive <= 1'b0;
    end else if (keyValid && !keyPrev) begin
      irqActive <= 1'b1; // [RULE10]
    end else if (state == RPS_RUN &&
                 (hostPowerKeep || timer >= HOLD_CYC[`RPS_CNT_W-1:0])) begin
      irqActive <= 1'b0; // [RULE12]
    end else if (state == RPS_OFF) begin
      irqActive <= 1'b0;
    end
  end

  // ****************************************
  // Enables and output enables, registered; open-drain data tied low
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      primaryRegulatorEn   <= 1'b0;
      secondaryRegulatorEn <= 1'b0;
      resetOutOe           <= 1'b1;
      irqOutOe             <= 1'b0;
    end else begin
      primaryRegulatorEn   <= (state != RPS_OFF);
      secondaryRegulatorEn <= (state == RPS_SEC_UP) || (state == RPS_RST_WAIT) ||
                              (state == RPS_RUN) || (state == RPS_SEC_DOWN);
      resetOutOe           <= (state != RPS_RUN); // [RULE14]
      irqOutOe             <= irqActive;
    end
  end

  assign resetOut_n = 1'b0;
  assign irqOut_n   = 1'b0;
endmodule

// [sim/rps_host_model.sv]
`timescale 1ns/100ps
module rps_host_model (
  input  wire logic       clk,
  input  wire logic       priEn,
  input  wire logic       secEn,
  input  wire logic       rstOe,
  input  wire logic       keepReq,
  output logic [9:0]      priLvl,
  output logic [9:0]      secLvl,
  output logic            keep
);
  function automatic logic [9:0] ramp(input logic [9:0] l, input logic en);
    if (en) return (l > 10'h3C8) ? 10'h3E8 : l + 10'h020;
    return (l < 10'h020) ? 10'h000 : l - 10'h020;
  endfunction
  initial priLvl = 10'h000;
  initial secLvl = 10'h000;
  // Rails ramp through both thresholds
  always @(posedge clk) begin
    priLvl <= ramp(priLvl, priEn);
    secLvl <= ramp(secLvl, secEn);
  end
  // Host holds power only once out of reset
  assign keep = keepReq && !rstOe;
endmodule

// [sim/rps_sequencer_props.sv]
`timescale 1ns/100ps
module rps_sequencer_props (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic [9:0] primaryLevel,
  input wire logic [9:0] secondaryLevel,
  input wire logic       primaryRegulatorEn,
  input wire logic       secondaryRegulatorEn,
  input wire logic       resetOut_n,
  input wire logic       resetOutOe,
  input wire logic       irqOut_n,
  input wire logic       irqOutOe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_sec_order: assert property ($rose(secondaryRegulatorEn) |->
    primaryRegulatorEn && primaryLevel >= 10'h3B6) else $error("secondary early");
  a_rst_order: assert property ($fell(resetOutOe) |->
    secondaryRegulatorEn && secondaryLevel >= 10'h3B6) else $error("reset early");
  a_rst_delay: assert property ($rose(secondaryRegulatorEn) |-> resetOutOe [*8])
    else $error("reset delay short");
  a_reset_state: assert property ($fell(srst) |-> resetOutOe && !irqOutOe &&
    !primaryRegulatorEn && !secondaryRegulatorEn) else $error("bad reset state");
  a_od_low: assert property (resetOut_n == 1'b0 && irqOut_n == 1'b0)
    else $error("open drain data high");
  a_sec_off_late: assert property ($rose(resetOutOe) && secondaryRegulatorEn |=>
    secondaryRegulatorEn [*8]) else $error("secondary off early");
  a_pri_off_order: assert property ($fell(primaryRegulatorEn) |->
    !secondaryRegulatorEn) else $error("primary off first");
  a_pri_off_late: assert property ($fell(secondaryRegulatorEn) |=>
    primaryRegulatorEn [*3]) else $error("primary off early");
  a_pri_first: assert property ($rose(primaryRegulatorEn) |->
    !secondaryRegulatorEn && resetOutOe) else $error("bad power-up start");
  cover property ($fell(resetOutOe));
  cover property ($fell(irqOutOe));
  cover property ($fell(primaryRegulatorEn));
endmodule
bind rps_sequencer rps_sequencer_props rps_sequencer_props_inst (.clk, .srst,
  .primaryLevel, .secondaryLevel, .primaryRegulatorEn, .secondaryRegulatorEn,
  .resetOut_n, .resetOutOe, .irqOut_n, .irqOutOe);

// [sim/regulator_power_sequencer_tb.sv]
`timescale 1ns/100ps
module regulator_power_sequencer_tb;
  localparam int DB = 8, RC = 10, RG = 5, RL = 12, HC = 40;
  logic       clk = 1'b0, srst = 1'b1, key = 1'b0, ext_n = 1'b1, keepReq = 1'b0;
  logic [9:0] pL, sL, pLL, sLL;
  logic       keep, pEn, sEn, rOe, iOe, keepL, pEnL, sEnL, rOeL;
  logic [9:0] pLQ = 10'h000, sLQ = 10'h000, pLLQ = 10'h000;
  logic       sEnQ = 1'b0, pEnQ = 1'b0, rOeQ = 1'b1, sEnLQ = 1'b0;
  int         n_errors = 0, cmp_count = 0, cyc = 0;
  int         tP1, tP2, tS, tR, tR1, tS0, tP20, tP0, tLP1, tLS;
  always #20 clk = ~clk;
  rps_sequencer #(.DEBOUNCE_CYC(DB), .RESET_CYC(RC), .REG_STD_CYC(RG),
    .REG_LONG_CYC(RL), .HOLD_CYC(HC)) rps_sequencer_inst (.clk, .srst,
    .powerKeyIn(key), .externalPowerDetect_n(ext_n), .hostPowerKeep(keep),
    .primaryLevel(pL), .secondaryLevel(sL), .primaryRegulatorEn(pEn),
    .secondaryRegulatorEn(sEn), .resetOut_n(), .resetOutOe(rOe), .irqOut_n(),
    .irqOutOe(iOe));
  rps_host_model rps_host_model_inst (.clk, .priEn(pEn), .secEn(sEn), .rstOe(rOe),
    .keepReq, .priLvl(pL), .secLvl(sL), .keep);
  // Same block built with the long regulator delay
  rps_sequencer #(.LONG_REG_DELAY(1'b1), .DEBOUNCE_CYC(DB), .RESET_CYC(RC),
    .REG_STD_CYC(RG), .REG_LONG_CYC(RL), .HOLD_CYC(HC)) rps_sequencer_long_inst (.clk,
    .srst, .powerKeyIn(key), .externalPowerDetect_n(ext_n), .hostPowerKeep(keepL),
    .primaryLevel(pLL), .secondaryLevel(sLL), .primaryRegulatorEn(pEnL),
    .secondaryRegulatorEn(sEnL), .resetOut_n(), .resetOutOe(rOeL), .irqOut_n(),
    .irqOutOe());
  rps_host_model rps_host_model_long_inst (.clk, .priEn(pEnL), .secEn(sEnL),
    .rstOe(rOeL), .keepReq, .priLvl(pLL), .secLvl(sLL), .keep(keepL));
  // Event times at the falling edge, once outputs have settled
  always @(negedge clk) begin
    pLQ   <= pL;
    sLQ   <= sL;
    pLLQ  <= pLL;
    sEnQ  <= sEn;
    pEnQ  <= pEn;
    rOeQ  <= rOe;
    sEnLQ <= sEnL;
    if (sEn && !sEnQ) tS <= cyc;
    if (!sEn && sEnQ) tS0 <= cyc;
    if (!pEn && pEnQ) tP0 <= cyc;
    if (!rOe && rOeQ) tR <= cyc;
    if (rOe && !rOeQ) tR1 <= cyc;
    if (pL >= 10'h3B6 && pLQ < 10'h3B6) tP1 <= cyc;
    if (sL >= 10'h3B6 && sLQ < 10'h3B6) tP2 <= cyc;
    if (sL <= 10'h384 && sLQ > 10'h384) tP20 <= cyc;
    if (pLL >= 10'h3B6 && pLLQ < 10'h3B6) tLP1 <= cyc;
    if (sEnL && !sEnLQ) tLS <= cyc;
  end
  // Cycle count and timeout
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      conclude();
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task inr(input int d, input int lo);
    chk(32'(d >= lo && d <= lo + 4), 32'h1);
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task done(input string s);
    tick(40);
    $display("test %s done", s);
  endtask
  task t_glitch;
    @(posedge clk) key <= 1'b1;
    tick(DB);
    key <= 1'b0;
    tick(12);
    chk(pEn, 1'b0);
    chk(iOe, 1'b0);
    done("short press");
  endtask
  task t_key_hold;
    @(posedge clk) key <= 1'b1;
    tick(DB);
    chk(pEn, 1'b0);
    tick(6);
    key <= 1'b0;
    chk(pEn, 1'b1);
    chk(iOe, 1'b1);
    while (rOe) @(posedge clk);
    inr(tS - tP1, RG);
    inr(tLS - tLP1, RL);
    inr(tR - tP2, RC);
    keepReq <= 1'b1;
    tick(4);
    chk(iOe, 1'b0);
    keepReq <= 1'b0;
    tick(4);
    chk(rOe, 1'b1);
    while (pEn) @(posedge clk);
    inr(tS0 - tR1, RC);
    inr(tP0 - tP20, RG);
    done("key with hold");
  endtask
  task t_timeout;
    @(posedge clk) key <= 1'b1;
    tick(14);
    key <= 1'b0;
    while (rOe) @(posedge clk);
    tick(HC + 6);
    inr(tR1 - tR, HC);
    chk(iOe, 1'b0);
    while (pEn) @(posedge clk);
    done("hold timeout");
  endtask
  task t_ext;
    @(posedge clk) ext_n <= 1'b0;
    tick(DB);
    chk(pEn, 1'b0);
    while (rOe) @(posedge clk);
    tick(HC + 10);
    chk(rOe, 1'b0);
    chk(pEn, 1'b1);
    ext_n <= 1'b1;
    tick(4);
    chk(rOe, 1'b1);
    while (pEn) @(posedge clk);
    done("external power");
  endtask
  task conclude;
    $display("counts: %0d compares, %0d mismatches", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    tick(8);
    srst <= 1'b0;
    chk(rOe, 1'b1);
    t_glitch;
    t_key_hold;
    t_timeout;
    t_ext;
    conclude;
  end
endmodule
